// file: sysstat_ctrl.sv
// file: system status signal control, top module
// Summary of operation
// RULE1 - external interrupt taken only while the external-interrupt enable bit is set.
// RULE2 - controller holds external interrupt asserted until taken; may arrive asynchronously.
// RULE3 - system management interrupt taken only while external-interrupt enable is set.
// RULE4 - controller holds system management request until the exception is taken.
// RULE5 - machine check raises exception when machine-check enable and pin enable set.
// RULE6 - machine check with pin enable but no check enable halts and floats outputs.
// RULE7 - machine check acts on falling edge; controller holds it two bus cycles.
// RULE8 - halt request input gates clocks and floats all outputs but halt indicator.
// RULE9 - controller holds halt request until reset, releases after indicator active.
// RULE10 - halt indicator asserts on halt, clears when hard reset asserts.
// RULE11 - hard reset release performs full reset and a reset exception.
// RULE12 - output drivers released within five clocks of hard reset assertion.
// RULE13 - reset logic holds hard reset 255 clocks after lock.
// RULE14 - soft reset falling edge starts reset exception; asynchronous input.
// RULE15 - quiesce request asserted to enter quiescent state, held throughout.
// RULE16 - snooping stops once quiescent.
// RULE17 - quiescent state entered only while grant asserted, else keep snooping.
// RULE18 - controller grants only after request, holds grant one cycle at least.
// RULE19 - grant sampled at hard reset release; asserted disables reduced-pinout mode.
// RULE20 - reservation output follows internal reservation bit, set by load-and-reserve.
// RULE21 - time base advances only while count enable asserted.
// RULE22 - translation-sync hold stops execution after translation-sync instruction.
// RULE23 - translation-sync hold sampled at reset release selects 32-bit bus.
// RULE24 - asynchronous interrupt, halt and reset inputs are synchronised first.
`timescale 1ns/100ps
`default_nettype none
module sysstat_ctrl #(
   parameter int TB_WIDTH = sysstat_pkg::TIMEBASE_WIDTH
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic hard_reset_n,
   input wire sysstat_pkg::async_pins_t async_pins,
   input wire logic ext_irq_enable_bit,
   input wire logic machine_check_enable_bit,
   input wire logic machine_check_pin_enable,
   input wire logic irq_taken,
   input wire logic quiesce_wanted,
   input wire logic quiesce_grant,
   input wire logic reserve_set,
   input wire logic reserve_clear,
   input wire logic timebase_count_enable,
   input wire logic translation_sync_hold,
   input wire logic tsync_done,
   output sysstat_pkg::exc_req_t exc_req,
   output logic halt_indicator_out,
   output logic halt_indicator_oe,
   output logic outputs_enable,
   output logic core_clock_enable,
   output logic quiesce_request,
   output logic snoop_enable,
   output logic reservation_flag_out,
   output logic exec_stall,
   output logic reduced_pinout_disable,
   output logic bus_32bit_mode,
   output logic [TB_WIDTH-1:0] timebase_count
);
   // ------------------------------------------------------------
   // input synchronisation
   // ------------------------------------------------------------
   sysstat_pkg::async_pins_t pins_lvl;
   logic hres_lvl;

   sysstat_sync #(.WIDTH(6), .RST_VAL(6'h3F)) u_sync (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .pin_in({async_pins, hard_reset_n}),
      .level_out({pins_lvl, hres_lvl})
   ); // [RULE24]

   logic mcp_prev_reg;
   logic srst_prev_reg;
   logic hres_prev_reg;
   wire logic mcp_fall;
   wire logic srst_fall;
   wire logic hres_assert;
   wire logic hres_release;
   wire logic in_reset;

   assign mcp_fall = mcp_prev_reg & ~pins_lvl.machine_check_n; // [RULE7]
   assign srst_fall = srst_prev_reg & ~pins_lvl.soft_reset_n; // [RULE14]
   assign hres_assert = hres_prev_reg & ~hres_lvl;
   assign hres_release = ~hres_prev_reg & hres_lvl; // [RULE11]
   assign in_reset = ~hres_lvl;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         mcp_prev_reg <= 1'b1;
         srst_prev_reg <= 1'b1;
         hres_prev_reg <= 1'b1; // matches synchroniser reset, so no false release edge
      end else begin
         mcp_prev_reg <= pins_lvl.machine_check_n;
         srst_prev_reg <= pins_lvl.soft_reset_n;
         hres_prev_reg <= hres_lvl;
      end
   end

   // ------------------------------------------------------------
   // run state
   // ------------------------------------------------------------
   sysstat_pkg::run_state_t state_reg;
   sysstat_pkg::run_state_t state_next;
   wire logic mc_halt;
   wire logic halt_cause;
   wire logic mc_exc;

   assign mc_exc = mcp_fall & machine_check_pin_enable & machine_check_enable_bit; // [RULE5]
   assign mc_halt = mcp_fall & machine_check_pin_enable & ~machine_check_enable_bit; // [RULE6]
   assign halt_cause = mc_halt | ~pins_lvl.halt_request_n; // [RULE8]

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         sysstat_pkg::ST_RESET: begin
            if (hres_release) begin
               state_next = sysstat_pkg::ST_RUN;
            end
         end
         sysstat_pkg::ST_RUN: begin
            if (halt_cause) begin
               state_next = sysstat_pkg::ST_HALTED;
            end else if (quiesce_wanted && quiesce_grant) begin
               state_next = sysstat_pkg::ST_QUIESCE; // [RULE17]
            end
         end
         sysstat_pkg::ST_QUIESCE: begin
            if (halt_cause) begin
               state_next = sysstat_pkg::ST_HALTED;
            end else if (!quiesce_wanted) begin
               state_next = sysstat_pkg::ST_RUN;
            end
         end
         sysstat_pkg::ST_HALTED: begin
            state_next = sysstat_pkg::ST_HALTED;
         end
         default: state_next = sysstat_pkg::ST_RESET;
      endcase
      // hard reset overrides everything, including a halt
      if (in_reset) begin
         state_next = sysstat_pkg::ST_RESET;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_reg <= sysstat_pkg::ST_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // ------------------------------------------------------------
   // output driver release after hard reset
   // ------------------------------------------------------------
   logic [2:0] rel_cnt_reg;
   logic drive_ok_reg;
   wire logic [2:0] rel_cnt_next;

   // drivers drop two cycles after reset is seen, well inside five clocks;
   // the counter only times the reset for the release check
   assign rel_cnt_next = !in_reset ? sysstat_pkg::RELEASE_CNT_RST :
                         (rel_cnt_reg == sysstat_pkg::RELEASE_CNT_MAX) ? rel_cnt_reg :
                         rel_cnt_reg + 3'h1;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rel_cnt_reg <= sysstat_pkg::RELEASE_CNT_RST;
         drive_ok_reg <= 1'b0;
      end else begin
         rel_cnt_reg <= rel_cnt_next;
         drive_ok_reg <= (state_next == sysstat_pkg::ST_RUN) ||
                         (state_next == sysstat_pkg::ST_QUIESCE); // [RULE12] [RULE8]
      end
   end

   // ------------------------------------------------------------
   // exceptions
   // ------------------------------------------------------------
   wire logic running;
   wire logic ei_take;
   wire logic smi_take;
   logic ei_pend_reg;

   assign running = (state_reg == sysstat_pkg::ST_RUN) || (state_reg == sysstat_pkg::ST_QUIESCE);
   // level requests: one pulse per assertion, rearmed by irq_taken
   assign ei_take = running & ext_irq_enable_bit & ~pins_lvl.ext_irq_n & ~ei_pend_reg; // [RULE1]
   assign smi_take = running & ext_irq_enable_bit & ~pins_lvl.sysmgmt_irq_n & ~ei_pend_reg; // [RULE3]

   always_ff @(posedge clk_sys) begin
      if (sys_rst || in_reset) begin
         ei_pend_reg <= 1'b0;
         exc_req <= '0;
      end else begin
         // new request wins over acknowledgment in the same cycle
         ei_pend_reg <= (ei_take | smi_take) | (ei_pend_reg & ~irq_taken);
         exc_req.ext_irq <= ei_take & ~smi_take;
         exc_req.sysmgmt_irq <= smi_take;
         exc_req.machine_check <= mc_exc & running;
         exc_req.soft_reset <= srst_fall & running; // [RULE14]
         exc_req.hard_reset <= 1'b0;
      end
      if (!sys_rst && hres_release) begin
         exc_req.hard_reset <= 1'b1; // [RULE11]
      end
   end

   // ------------------------------------------------------------
   // status outputs and straps
   // ------------------------------------------------------------
   logic [TB_WIDTH-1:0] tb_reg;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         halt_indicator_out <= 1'b0;
         halt_indicator_oe <= 1'b0;
         outputs_enable <= 1'b0;
         core_clock_enable <= 1'b0;
         quiesce_request <= 1'b0;
         snoop_enable <= 1'b0;
         reservation_flag_out <= 1'b0;
         exec_stall <= 1'b0;
         reduced_pinout_disable <= 1'b0;
         bus_32bit_mode <= 1'b0;
         tb_reg <= '0;
      end else begin
         // open drain: pull low only while halted
         halt_indicator_out <= 1'b0;
         halt_indicator_oe <= (state_next == sysstat_pkg::ST_HALTED); // [RULE10]
         outputs_enable <= drive_ok_reg & (state_next != sysstat_pkg::ST_HALTED); // [RULE12]
         core_clock_enable <= (state_next != sysstat_pkg::ST_HALTED); // [RULE6] [RULE8]
         quiesce_request <= drive_ok_reg & quiesce_wanted; // [RULE15]
         snoop_enable <= (state_next == sysstat_pkg::ST_RUN); // [RULE16] [RULE17]
         if (in_reset || reserve_clear) begin
            reservation_flag_out <= reserve_set & ~in_reset;
         end else if (reserve_set) begin
            reservation_flag_out <= 1'b1; // [RULE20]
         end
         exec_stall <= translation_sync_hold & tsync_done; // [RULE22]
         if (hres_release) begin
            reduced_pinout_disable <= quiesce_grant; // [RULE19]
            bus_32bit_mode <= translation_sync_hold; // [RULE23]
         end
         if (in_reset) begin
            tb_reg <= '0;
         end else if (timebase_count_enable && core_clock_enable) begin
            tb_reg <= tb_reg + 1'b1; // [RULE21]
         end
      end
   end
   assign timebase_count = tb_reg;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   chk_ei_masked: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE1]
      !ext_irq_enable_bit |=> !exc_req.ext_irq) else $error("ext irq taken while masked");
   chk_smi_masked: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE3]
      !ext_irq_enable_bit |=> !exc_req.sysmgmt_irq) else $error("smi taken while masked");
   chk_mc_exc: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE5]
      exc_req.machine_check |-> $past(machine_check_pin_enable) && $past(machine_check_enable_bit))
      else $error("machine check without enables");
   chk_mc_halt: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE6]
      (mc_halt && hres_lvl) |=> !core_clock_enable && halt_indicator_oe)
      else $error("machine check did not halt");
   chk_halt_float: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE8]
      halt_indicator_oe |-> !outputs_enable) else $error("outputs driven while halted");
   chk_ind_clear: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE10]
      in_reset |=> !halt_indicator_oe) else $error("halt indicator not cleared");
   chk_hres_exc: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE11]
      hres_release |=> exc_req.hard_reset) else $error("no reset exception");
   chk_drv_release: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE12]
      hres_assert |-> ##[1:5] !outputs_enable) else $error("drivers not released");
   chk_drv_count: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE12]
      (in_reset && rel_cnt_reg == sysstat_pkg::RELEASE_CNT_MAX) |-> !outputs_enable)
      else $error("drivers still on deep in reset");
   chk_quiesce_grant: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE17]
      (state_reg == sysstat_pkg::ST_RUN && !quiesce_grant) |=> state_reg != sysstat_pkg::ST_QUIESCE)
      else $error("quiescent without grant");
   chk_tb_hold: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE21]
      (!timebase_count_enable && !in_reset) |=> $stable(timebase_count)) else $error("time base moved");
   chk_bus_strap: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE23]
      hres_release |=> bus_32bit_mode == $past(translation_sync_hold)) else $error("bus strap wrong");

   cov_quiesce: cover property (@(posedge clk_sys) disable iff (sys_rst)
      state_reg == sysstat_pkg::ST_QUIESCE);
   cov_halt: cover property (@(posedge clk_sys) disable iff (sys_rst) halt_indicator_oe);
   cov_srst: cover property (@(posedge clk_sys) disable iff (sys_rst) exc_req.soft_reset);
   cov_ei: cover property (@(posedge clk_sys) disable iff (sys_rst) exc_req.ext_irq);
endmodule : sysstat_ctrl
`default_nettype wire

// file: sysstat_pkg.sv
// package: constants and carrier types for the system status signal control block
package sysstat_pkg;
   localparam int SYNC_STAGES = 3;
   localparam int DRIVER_RELEASE_CYCLES = 5;
   localparam logic [2:0] RELEASE_CNT_RST = 3'h0;
   localparam logic [2:0] RELEASE_CNT_MAX = 3'h4;
   localparam int TIMEBASE_WIDTH = 64;
   localparam logic [63:0] TIMEBASE_RST = 64'h0000000000000000;

   // inputs from the system controller, all active low on the pins
   typedef struct packed {
      logic ext_irq_n;
      logic sysmgmt_irq_n;
      logic machine_check_n;
      logic halt_request_n;
      logic soft_reset_n;
   } async_pins_t;

   // exception requests towards the core, all one-cycle pulses
   typedef struct packed {
      logic ext_irq;
      logic sysmgmt_irq;
      logic machine_check;
      logic soft_reset;
      logic hard_reset;
   } exc_req_t;

   typedef enum logic [3:0] {
      ST_RESET = 4'h1,
      ST_RUN = 4'h2,
      ST_QUIESCE = 4'h4,
      ST_HALTED = 4'h8
   } run_state_t;
endpackage : sysstat_pkg

// file: sysstat_sync.sv
// file: three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module sysstat_sync #(
   parameter int WIDTH = 5,
   parameter logic [WIDTH-1:0] RST_VAL = '1
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level_out
);
   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;
   logic [WIDTH-1:0] level_reg;
   wire logic [WIDTH-1:0] agree;
   wire logic [WIDTH-1:0] level_next;

   // s1 feeds only s2; the filter compares s2 with s3
   assign agree = ~(s2_reg ^ s3_reg);
   assign level_next = (agree & s3_reg) | (~agree & level_reg);

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         s1_reg <= RST_VAL;
         s2_reg <= RST_VAL;
         s3_reg <= RST_VAL;
         level_reg <= RST_VAL;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         level_reg <= level_next;
      end
   end
   assign level_out = level_reg;
endmodule : sysstat_sync
`default_nettype wire

// file: sysctl_model.sv
// system controller model that drives the status pins of the block
`timescale 1ns/100ps
`default_nettype none
module sysctl_model (
   input wire logic clk_sys,
   input wire sysstat_pkg::exc_req_t exc_req,
   input wire logic quiesce_request,
   input wire logic grant_allow,
   input wire logic grant_strap,
   output var sysstat_pkg::async_pins_t async_pins,
   output wire logic quiesce_grant
);
   logic grant_reg;
   initial begin
      async_pins = '1;
      grant_reg = 1'h0;
   end
   // grant only a cycle after the request, and kept while it stands
   always @(posedge clk_sys) grant_reg <= #1 quiesce_request & grant_allow;
   assign quiesce_grant = grant_strap | grant_reg;
   // levels stay asserted until the exception is taken, then drop
   always @(posedge clk_sys) begin
      if (exc_req.ext_irq) async_pins.ext_irq_n <= #1 1'h1;
      if (exc_req.sysmgmt_irq) async_pins.sysmgmt_irq_n <= #1 1'h1;
   end
   task automatic set_pin(input int idx, input logic val);
      async_pins[idx] = val;
   endtask : set_pin
   // edge pins never shorter than two bus cycles
   task automatic pulse_pin(input int idx, input int cycles);
      async_pins[idx] = 1'h0;
      repeat (cycles < 2 ? 2 : cycles) @(posedge clk_sys);
      #1 async_pins[idx] = 1'h1;
   endtask : pulse_pin
endmodule : sysctl_model
`default_nettype wire

// file: testbench.sv
// self-checking testbench for the system status signal control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
   localparam int P_EXT = 4, P_SMI = 3, P_MCP = 2, P_HALT = 1, P_SRST = 0;
   logic clk_sys = 1'h0, sys_rst = 1'h1, hard_reset_n = 1'h0, ee = 1'h0, me = 1'h1, mpe = 1'h0;
   logic irq_taken = 1'h0, q_want = 1'h0, r_set = 1'h0, r_clr = 1'h0, tb_en = 1'h0;
   logic ts_hold = 1'h1, ts_done = 1'h0, g_allow = 1'h0, g_strap = 1'h1;
   logic q_req, q_grant, h_out, h_oe, o_en, ck_en, snoop, rsv, stall, rpd, b32;
   logic [63:0] tbc, t0;
   sysstat_pkg::async_pins_t pins;
   sysstat_pkg::exc_req_t exc;
   sysstat_pkg::exc_req_t exp_q[$];
   int mismatches = 0, comparisons = 0, seed = 32'h06CA146A;
   always #2 clk_sys = ~clk_sys;
   sysstat_ctrl dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .hard_reset_n(hard_reset_n),
      .async_pins(pins), .ext_irq_enable_bit(ee), .machine_check_enable_bit(me),
      .machine_check_pin_enable(mpe), .irq_taken(irq_taken), .quiesce_wanted(q_want),
      .quiesce_grant(q_grant), .reserve_set(r_set), .reserve_clear(r_clr),
      .timebase_count_enable(tb_en), .translation_sync_hold(ts_hold), .tsync_done(ts_done),
      .exc_req(exc), .halt_indicator_out(h_out), .halt_indicator_oe(h_oe),
      .outputs_enable(o_en), .core_clock_enable(ck_en), .quiesce_request(q_req),
      .snoop_enable(snoop), .reservation_flag_out(rsv), .exec_stall(stall),
      .reduced_pinout_disable(rpd), .bus_32bit_mode(b32), .timebase_count(tbc));
   sysctl_model model_u (.clk_sys(clk_sys), .exc_req(exc), .quiesce_request(q_req),
      .grant_allow(g_allow), .grant_strap(g_strap), .async_pins(pins),
      .quiesce_grant(q_grant));
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : cyc
   // exception pulses are paired with the oldest note; a stray one is a mismatch
   always @(negedge clk_sys) begin
      if (exc !== '0) begin
         if (exp_q.size() == 0)
            check(exc, 64'h0);
         else
            check(exc, exp_q.pop_front());
      end
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      results();
   end
   // hard reset held past its minimum, then released with the straps set
   task automatic hard_reset(input logic straps);
      hard_reset_n = 1'h0;
      cyc(5);
      check(o_en, 1'h0);
      check(h_oe, 1'h0);
      model_u.set_pin(P_HALT, 1'h1);
      g_strap = straps;
      ts_hold = straps;
      cyc(260);
      exp_q.push_back(5'h01);
      hard_reset_n = 1'h1;
      cyc(12);
      g_strap = 1'h0;
      ts_hold = 1'h0;
      check(rpd, straps);
      check(b32, straps);
      check({ck_en, o_en}, 2'h3);
   endtask : hard_reset
   initial begin
      cyc(8);
      sys_rst = 1'h0;
      hard_reset(1'h1);
      $display("test reset done");
      for (int i = 0; i < 2; i++) begin
         ee = 1'h0;
         model_u.set_pin(i ? P_SMI : P_EXT, 1'h0);
         cyc(20); // a disabled request raises nothing
         exp_q.push_back(i ? 5'h08 : 5'h10);
         ee = 1'h1;
         cyc(20);
         irq_taken = 1'h1;
         cyc(1);
         irq_taken = 1'h0;
      end
      model_u.pulse_pin(P_MCP, 3);
      cyc(12); // pin enable clear: ignored
      mpe = 1'h1;
      exp_q.push_back(5'h04);
      model_u.pulse_pin(P_MCP, 2 + $unsigned($random(seed)) % 8);
      cyc(12);
      exp_q.push_back(5'h02);
      model_u.pulse_pin(P_SRST, 2);
      cyc(12);
      check(exp_q.size(), 0);
      $display("test exceptions done");
      q_want = 1'h1;
      cyc(10);
      check({q_req, snoop}, 2'h3); // no grant yet, still snooping
      g_allow = 1'h1;
      cyc(6);
      check({q_req, snoop}, 2'h2);
      q_want = 1'h0;
      cyc(6);
      check({q_req, snoop}, 2'h1);
      g_allow = 1'h0;
      for (int i = 0; i < 8; i++) begin
         tb_en = $random(seed);
         cyc(1);
         t0 = tbc;
         cyc(5);
         check(tbc - t0, tb_en ? 64'h5 : 64'h0);
      end
      r_set = 1'h1;
      cyc(1);
      r_set = 1'h0;
      cyc(2);
      check(rsv, 1'h1);
      r_clr = 1'h1;
      cyc(1);
      r_clr = 1'h0;
      cyc(2);
      check(rsv, 1'h0);
      ts_hold = 1'h1;
      ts_done = 1'h1;
      cyc(3);
      check(stall, 1'h1);
      ts_hold = 1'h0;
      cyc(3);
      check(stall, 1'h0);
      ts_done = 1'h0;
      $display("test status done");
      // halt by the halt input, then by machine check with checking off
      for (int i = 0; i < 2; i++) begin
         me = i ? 1'h0 : 1'h1;
         if (i)
            model_u.pulse_pin(P_MCP, 3);
         else
            model_u.set_pin(P_HALT, 1'h0);
         cyc(12);
         check({ck_en, o_en, h_oe, h_out}, 4'h2);
         hard_reset(1'h0);
      end
      $display("test halt done");
      check(exp_q.size(), 0);
      results();
   end
endmodule : testbench
`default_nettype wire
